// ==== hdl/cms_pkg.sv ====
// Constants, types and helpers shared by the CPU clock mode selector
`default_nettype none

package cms_pkg;

  // -------------------------------------------------------------------------
  // Strap codes
  // -------------------------------------------------------------------------
  localparam logic [2:0] STRAP_X4       = 3'h7;
  localparam logic [2:0] STRAP_X3       = 3'h6;
  localparam logic [2:0] STRAP_X2       = 3'h5;
  localparam logic [2:0] STRAP_X5       = 3'h4;
  localparam logic [2:0] STRAP_DIRECT   = 3'h3;
  localparam logic [2:0] STRAP_X1P5     = 3'h2;
  localparam logic [2:0] STRAP_PRESCALE = 3'h1;
  localparam logic [2:0] STRAP_X2P5     = 3'h0;

  // -------------------------------------------------------------------------
  // Multiplication factors, held as twice the factor
  // -------------------------------------------------------------------------
  localparam logic [3:0] FX2_X1   = 4'h2;
  localparam logic [3:0] FX2_X1P5 = 4'h3;
  localparam logic [3:0] FX2_X2   = 4'h4;
  localparam logic [3:0] FX2_X2P5 = 4'h5;
  localparam logic [3:0] FX2_X3   = 4'h6;
  localparam logic [3:0] FX2_X4   = 4'h8;
  localparam logic [3:0] FX2_X5   = 4'ha;

  // -------------------------------------------------------------------------
  // Positions of the synchronised pins and timing
  // -------------------------------------------------------------------------
  localparam int         SYNC_W       = 5;
  localparam int         POS_OSC      = 0;
  localparam int         POS_WDOG     = 1;
  localparam int         POS_STRAP_LO = 2;
  localparam int         POS_STRAP_HI = 4;
  localparam int         CLK_PERIOD_NS = 5;
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
  localparam int         PLL_GAIN_SHIFT = 2;
  localparam logic [1:0] WIN_RESET = 2'h0;

  typedef enum logic [1:0]
  {
    CMS_WAIT     = 2'b00,
    CMS_DIRECT   = 2'b01,
    CMS_PLL      = 2'b11,
    CMS_PRESCALE = 2'b10
  } cms_mode_t;

  // Factor (x2) selected by a strap code
  function automatic logic [3:0] strap_factor_x2(input logic [2:0] code);
    logic [3:0] f;
    f = FX2_X4;
    unique case (code)
      STRAP_X4:       f = FX2_X4;
      STRAP_X3:       f = FX2_X3;
      STRAP_X2:       f = FX2_X2;
      STRAP_X5:       f = FX2_X5;
      STRAP_X1P5:     f = FX2_X1P5;
      STRAP_X2P5:     f = FX2_X2P5;
      STRAP_DIRECT:   f = FX2_X1;
      STRAP_PRESCALE: f = FX2_X1;
    endcase
    return f;
  endfunction

endpackage

`default_nettype wire

// ==== hdl/cms_sync.sv ====
// Two-stage synchroniser for asynchronous pin inputs
`default_nettype none

module cms_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,    // System clock
  input  wire logic         rst_n,  // Asynchronous reset, active low
  input  wire logic         ce,     // Clock enable
  input  wire logic [W-1:0] d,      // Asynchronous inputs
  output logic      [W-1:0] q       // Synchronised outputs
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      q        <= '0;
    end
    else if (ce)
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

`default_nettype wire

// ==== hdl/cms_clock_mode_select.sv ====
// CPU clock generator whose mode is chosen by strap pins just after reset release
// Operation
// - CPU clock edges of both kinds flagged; half period is the basic timing unit
// - Mode taken from three strap pins, port-0 bits fifteen to thirteen, just after reset release
// - Codes 111 x4, 110 x3, 101 x2, 100 x5, 010 x1.5, 000 x2.5
// - Code 001 divides oscillator by two; each half period is one oscillator period
// - Code 011 turns the multiplier off and passes oscillator straight through
// - Watchdog enable pin low forces direct drive instead of any multiplier mode
// - Direct drive: two consecutive half periods always equal one oscillator period
// - All other codes run the multiplier: CPU clock is oscillator times factor
// - Multiplier resyncs every factor-count, rounded up, of input transitions, adjusting gradually
`default_nettype none

module cms_clock_mode_select #(
  parameter int CNT_W = 16
) (
  input  wire logic             clk,                     // System clock, 200 MHz
  input  wire logic             rst_n,                   // Asynchronous reset, active low
  input  wire logic             ce,                      // Clock enable, freezes all state
  input  wire logic             osc_in_pin,              // Oscillator input pin
  input  wire logic             osc_watchdog_enable_pin, // Low forces direct drive unless code is 001
  input  wire logic [2:0]       clock_mode_strap_pins,   // Mode strap pins
  output logic                  cpu_clk,                 // Generated CPU clock level
  output logic                  cpu_edge,                // Pulse after each CPU clock edge
  output logic                  cpu_rise,                // Pulse after a rising CPU edge
  output logic                  pll_enable,              // Multiplier running
  output logic                  direct_drive,            // Direct drive active
  output logic                  prescale_active,         // Divide-by-two active
  output logic                  mode_latched,            // Mode captured after reset
  output logic [2:0]            clock_mode_strap_bits,   // Latched strap code
  output logic [3:0]            pll_factor_x2            // Twice the active factor
);

  // -------------------------------------------------------------------------
  // Pin synchronisation
  // -------------------------------------------------------------------------
  logic [cms_pkg::SYNC_W-1:0] sync_q;
  logic                       osc_s;
  logic                       wdog_s;
  logic [2:0]                 strap_s;

  cms_sync #(
    .W (cms_pkg::SYNC_W)
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .d     ({clock_mode_strap_pins, osc_watchdog_enable_pin, osc_in_pin}),
    .q     (sync_q)
  );

  assign osc_s   = sync_q[cms_pkg::POS_OSC];
  assign wdog_s  = sync_q[cms_pkg::POS_WDOG];
  assign strap_s = sync_q[cms_pkg::POS_STRAP_HI:cms_pkg::POS_STRAP_LO];

  // -------------------------------------------------------------------------
  // Mode capture after reset release
  // -------------------------------------------------------------------------
  cms_pkg::cms_mode_t mode_reg;
  logic [1:0]         settle_reg;
  logic [2:0]         strap_reg;
  logic [3:0]         fx2_reg;
  cms_pkg::cms_mode_t mode_next;

  always_comb
  begin
    if (strap_s == cms_pkg::STRAP_PRESCALE)
      mode_next = cms_pkg::CMS_PRESCALE;
    else if (strap_s == cms_pkg::STRAP_DIRECT || !wdog_s)
      mode_next = cms_pkg::CMS_DIRECT;
    else
      mode_next = cms_pkg::CMS_PLL;
  end

  // Waits for the synchroniser to fill, then captures once
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      settle_reg <= 2'h0;
      mode_reg   <= cms_pkg::CMS_WAIT;
      strap_reg  <= 3'h0;
      fx2_reg    <= 4'h0;
    end
    else if (ce && mode_reg == cms_pkg::CMS_WAIT)
    begin
      if (settle_reg == cms_pkg::STRAP_SETTLE)
      begin
        mode_reg  <= mode_next;
        strap_reg <= strap_s;
        fx2_reg   <= (mode_next == cms_pkg::CMS_PLL) ?
                     cms_pkg::strap_factor_x2(strap_s) : cms_pkg::FX2_X1;
      end
      else
      begin
        settle_reg <= settle_reg + 2'h1;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Oscillator transition detect
  // -------------------------------------------------------------------------
  logic osc_d_reg;
  logic osc_tr;
  logic osc_rise;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      osc_d_reg <= 1'b0;
    else if (ce)
      osc_d_reg <= osc_s;
  end

  assign osc_tr   = osc_s ^ osc_d_reg;
  assign osc_rise = osc_s & ~osc_d_reg;

  // -------------------------------------------------------------------------
  // Multiplier: fractional divider locked to the oscillator
  // -------------------------------------------------------------------------
  // Per clk the accumulator gains fx2*W and pays out thr per CPU edge.
  // thr tracks 2*M, M being clk cycles across W oscillator transitions,
  // so the edge rate is fx2 per oscillator period, free of any divider.
  logic [2:0]       win_len;
  logic [5:0]       step;
  logic [2:0]       tr_cnt_reg;
  logic [CNT_W-1:0] win_cyc_reg;
  logic [CNT_W:0]   thr_reg;
  logic [CNT_W:0]   acc_reg;
  logic [CNT_W:0]   acc_sum;
  logic [CNT_W:0]   target;
  logic             win_end;
  logic             pll_tick;

  assign win_len  = 3'((fx2_reg + 4'h1) >> 1);
  assign step     = 6'(fx2_reg) * 6'(win_len);
  assign win_end  = osc_tr && (tr_cnt_reg == win_len - 3'h1);
  assign target   = {win_cyc_reg + CNT_W'(1), 1'b0};
  assign acc_sum  = acc_reg + (CNT_W+1)'(step);
  assign pll_tick = (mode_reg == cms_pkg::CMS_PLL) && (acc_sum >= thr_reg);

  // Moves thr a fraction of the error per window, never a jump
  function automatic logic [CNT_W:0] slew(input logic [CNT_W:0] cur,
                                          input logic [CNT_W:0] tgt);
    logic [CNT_W:0] diff;
    diff = '0;
    if (tgt > cur)
    begin
      diff = (tgt - cur) >> cms_pkg::PLL_GAIN_SHIFT;
      return cur + ((diff == '0) ? (CNT_W+1)'(1) : diff);
    end
    else if (tgt < cur)
    begin
      diff = (cur - tgt) >> cms_pkg::PLL_GAIN_SHIFT;
      return cur - ((diff == '0) ? (CNT_W+1)'(1) : diff);
    end
    return cur;
  endfunction

  // Window counting and resynchronisation
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tr_cnt_reg  <= 3'h0;
      win_cyc_reg <= '0;
      thr_reg     <= '1;
    end
    else if (ce && mode_reg == cms_pkg::CMS_PLL)
    begin
      if (win_end)
      begin
        tr_cnt_reg  <= 3'(cms_pkg::WIN_RESET);
        win_cyc_reg <= '0;
        thr_reg     <= slew(thr_reg, target);
      end
      else
      begin
        if (osc_tr)
          tr_cnt_reg <= tr_cnt_reg + 3'h1;
        if (win_cyc_reg != '1)
          win_cyc_reg <= win_cyc_reg + CNT_W'(1);
      end
    end
  end

  // Phase accumulator; saturates to one edge per clk when too fast
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      acc_reg <= '0;
    else if (ce && mode_reg == cms_pkg::CMS_PLL)
    begin
      if (pll_tick)
        acc_reg <= (acc_sum - thr_reg >= thr_reg) ? '0 : acc_sum - thr_reg;
      else
        acc_reg <= acc_sum;
    end
  end

  // -------------------------------------------------------------------------
  // CPU clock output
  // -------------------------------------------------------------------------
  logic cpu_clk_next;

  always_comb
  begin
    cpu_clk_next = cpu_clk;
    unique case (mode_reg)
      cms_pkg::CMS_WAIT:     cpu_clk_next = 1'b0;
      cms_pkg::CMS_DIRECT:   cpu_clk_next = osc_s;
      cms_pkg::CMS_PRESCALE: cpu_clk_next = cpu_clk ^ osc_rise;
      cms_pkg::CMS_PLL:      cpu_clk_next = cpu_clk ^ pll_tick;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpu_clk  <= 1'b0;
      cpu_edge <= 1'b0;
      cpu_rise <= 1'b0;
    end
    else if (ce)
    begin
      cpu_clk  <= cpu_clk_next;
      cpu_edge <= cpu_clk_next ^ cpu_clk;
      cpu_rise <= cpu_clk_next & ~cpu_clk;
    end
  end

  // -------------------------------------------------------------------------
  // Status outputs
  // -------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pll_enable            <= 1'b0;
      direct_drive          <= 1'b0;
      prescale_active       <= 1'b0;
      mode_latched          <= 1'b0;
      clock_mode_strap_bits <= 3'h0;
      pll_factor_x2         <= 4'h0;
    end
    else if (ce)
    begin
      pll_enable            <= (mode_reg == cms_pkg::CMS_PLL);
      direct_drive          <= (mode_reg == cms_pkg::CMS_DIRECT);
      prescale_active       <= (mode_reg == cms_pkg::CMS_PRESCALE);
      mode_latched          <= (mode_reg != cms_pkg::CMS_WAIT);
      clock_mode_strap_bits <= strap_reg;
      pll_factor_x2         <= fx2_reg;
    end
  end

endmodule

`default_nettype wire

// ==== tb/cms_monitor.sv ====
// Assertion checker for the CPU clock mode selector
`default_nettype none
module cms_monitor #(
  parameter int CNT_W = 16
) (
  input wire logic       clk,                     // System clock
  input wire logic       rst_n,                   // Reset, active low
  input wire logic       ce,                      // Clock enable
  input wire logic       osc_in_pin,              // Oscillator pin
  input wire logic       osc_watchdog_enable_pin, // Watchdog enable
  input wire logic [2:0] clock_mode_strap_pins,   // Strap pins
  input wire logic       cpu_clk,                 // CPU clock
  input wire logic       cpu_edge,                // Any edge pulse
  input wire logic       cpu_rise,                // Rising edge pulse
  input wire logic       pll_enable,              // Multiplier mode
  input wire logic       direct_drive,            // Direct mode
  input wire logic       prescale_active,         // Prescaler mode
  input wire logic       mode_latched,            // Mode captured
  input wire logic [2:0] clock_mode_strap_bits,   // Latched code
  input wire logic [3:0] pll_factor_x2            // Factor times two
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  logic [3:0] osc_h;
  logic [2:0] rel_cnt;
  function automatic logic [3:0] fx(input logic [2:0] c);
    case (c)
      3'h7: return 4'h8;
      3'h6: return 4'h6;
      3'h5: return 4'h4;
      3'h4: return 4'ha;
      3'h2: return 4'h3;
      3'h0: return 4'h5;
      default: return 4'h2;
    endcase
  endfunction
  always_ff @(posedge clk) osc_h <= {osc_h[2:0], osc_in_pin};
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) rel_cnt <= 3'h0;
    else if (rel_cnt != 3'h7) rel_cnt <= rel_cnt + 3'h1;
  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_toggle;
    $changed(cpu_clk);
  endsequence
  sequence s_pulse;
    cpu_rise ##1 !cpu_rise;
  endsequence
  // Edge pulses are registered on the same clk edge as the new clock level
  a_edge_pulse: assert property (s_toggle |-> cpu_edge)
    else $error("edge pulse missing");
  a_rise_pulse: assert property ($rose(cpu_clk) |-> s_pulse)
    else $error("rise pulse wrong");
  a_edge_cause: assert property (cpu_edge |-> s_toggle)
    else $error("edge pulse without edge");
  a_latch_time: assert property (mode_latched == (rel_cnt >= 3'h4))
    else $error("mode latched at wrong cycle");
  a_mode_kind: assert property (mode_latched |-> $onehot({pll_enable, direct_drive,
    prescale_active}) && prescale_active == (clock_mode_strap_bits == 3'h1)
    && !(pll_enable && clock_mode_strap_bits == 3'h3))
    else $error("mode flags wrong");
  a_factor_map: assert property (mode_latched |->
    pll_factor_x2 == (pll_enable ? fx(clock_mode_strap_bits) : 4'h2))
    else $error("factor wrong");
  a_mode_hold: assert property (mode_latched |=> mode_latched && $stable({pll_enable,
    direct_drive, clock_mode_strap_bits, pll_factor_x2}))
    else $error("mode changed after capture");
  a_direct_follow: assert property (direct_drive && $past(direct_drive, 4)
    |-> cpu_clk == osc_h[2])
    else $error("direct clock does not follow oscillator");
  a_prescale_step: assert property (prescale_active && $past(prescale_active, 5)
    |-> $changed(cpu_clk) == (osc_h[2] && !osc_h[3]))
    else $error("prescaler toggle wrong");
endmodule
bind cms_clock_mode_select cms_monitor #(.CNT_W(CNT_W)) i_mon (.clk(clk), .rst_n(rst_n),
  .ce(ce), .osc_in_pin(osc_in_pin), .osc_watchdog_enable_pin(osc_watchdog_enable_pin),
  .clock_mode_strap_pins(clock_mode_strap_pins), .cpu_clk(cpu_clk), .cpu_edge(cpu_edge),
  .cpu_rise(cpu_rise), .pll_enable(pll_enable), .direct_drive(direct_drive),
  .prescale_active(prescale_active), .mode_latched(mode_latched),
  .clock_mode_strap_bits(clock_mode_strap_bits), .pll_factor_x2(pll_factor_x2));
`default_nettype wire

// ==== tb/cms_osc_model.sv ====
// Oscillator source with adjustable high and low times
`default_nettype none
module cms_osc_model (
  input wire logic       clk,   // Bench clock
  input wire logic [7:0] hi_c,  // High time in cycles
  input wire logic [7:0] lo_c,  // Low time in cycles
  output var logic       osc    // Oscillator output
);
  timeunit 1ns;
  timeprecision 1ps;
  int   n = 0;
  logic osc_reg = 1'b0;
  assign osc = osc_reg;
  always @(negedge clk)
  begin
    n++;
    if (n >= int'(osc_reg ? hi_c : lo_c))
    begin
      osc_reg <= !osc_reg;
      n = 0;
    end
  end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the CPU clock mode selector
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       wdog = 1'b1;
  logic [2:0] straps = 3'h7;
  logic [7:0] hi_c = 8'h14;
  logic [7:0] lo_c = 8'h14;
  logic       osc, cpu_clk, cpu_edge, cpu_rise, pll_en, dd, pa, ml;
  logic [2:0] bits;
  logic [3:0] fx2;
  int         n_mismatch = 0;
  int         check_count = 0;
  int         cyc = 0;
  int         e, h;
  localparam logic [3:0] FX [8] = '{4'h5, 4'h2, 4'h3, 4'h2, 4'ha, 4'h4, 4'h6, 4'h8};
  // --------------------------------------------------------------
  // Harness
  // --------------------------------------------------------------
  cms_osc_model i_osc (.clk(clk), .hi_c(hi_c), .lo_c(lo_c), .osc(osc));
  cms_clock_mode_select #(.CNT_W(10)) i_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1),
    .osc_in_pin(osc), .osc_watchdog_enable_pin(wdog), .clock_mode_strap_pins(straps),
    .cpu_clk(cpu_clk), .cpu_edge(cpu_edge), .cpu_rise(cpu_rise), .pll_enable(pll_en),
    .direct_drive(dd), .prescale_active(pa), .mode_latched(ml),
    .clock_mode_strap_bits(bits), .pll_factor_x2(fx2));
  always #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 50000)
    begin
      n_mismatch++;
      give_verdict;
    end
  end
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] s, input logic [15:0] x);
    check_count++;
    if (s !== x)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, x, s);
    end
  endtask
  task boot(input logic [2:0] c, input logic w);
    @(negedge clk);
    straps = c;
    wdog = w;
    rst_n = 1'b0;
    repeat (12) @(negedge clk);
    chk("latched_in_reset", 16'(ml), 16'h0);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask
  task meas(input int n);
    e = 0;
    h = 0;
    repeat (n)
    begin
      @(posedge clk);
      #1;
      e += int'(cpu_edge === 1'b1);
      h += int'(cpu_clk === 1'b1);
    end
  endtask
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task t_codes;
    for (int c = 0; c < 8; c++)
    begin
      boot(3'(c), 1'b1);
      chk("latched", 16'(ml), 16'h1);
      chk("bits", 16'(bits), 16'(c));
      chk("fx2", 16'(fx2), 16'(FX[c]));
      chk("pll", 16'(pll_en), 16'(c != 1 && c != 3));
      chk("direct", 16'(dd), 16'(c == 3));
      chk("prescale", 16'(pa), 16'(c == 1));
    end
    $display("t_codes done");
  endtask
  task t_wdog;
    boot(3'h7, 1'b0);
    chk("wd_direct", 16'(dd), 16'h1);
    chk("wd_fx2", 16'({pll_en, fx2}), 16'h2);
    boot(3'h1, 1'b0);
    chk("wd_prescale", 16'(pa), 16'h1);
    $display("t_wdog done");
  endtask
  task t_direct;
    hi_c = 8'h03;
    lo_c = 8'h07;
    boot(3'h3, 1'b1);
    meas(100);
    chk("dir_edges", 16'(e), 16'd20);
    chk("dir_high", 16'(h), 16'd30);
    $display("t_direct done");
  endtask
  task t_prescale;
    hi_c = 8'h02;
    lo_c = 8'h06;
    boot(3'h1, 1'b1);
    meas(160);
    chk("pre_edges", 16'(e), 16'd20);
    chk("pre_high", 16'(h), 16'd80);
    @(negedge clk);
    straps = 3'h3;
    wdog = 1'b0;
    repeat (20) @(negedge clk);
    chk("hold_bits", 16'({pa, bits}), 16'h9);
    $display("t_prescale done");
  endtask
  task automatic t_pll;
    logic [2:0] cs [3] = '{3'h5, 3'h4, 3'h2};
    int x;
    hi_c = 8'h14;
    lo_c = 8'h14;
    foreach (cs[i])
    begin
      boot(cs[i], 1'b1);
      repeat (10000) @(negedge clk);
      meas(800);
      x = 20 * int'(FX[cs[i]]);
      chk("pll_rate", 16'(e >= x - 2 && e <= x + 2), 16'h1);
    end
    $display("t_pll done");
  endtask
  initial
  begin
    t_codes;
    t_wdog;
    t_direct;
    t_prescale;
    t_pll;
    give_verdict;
  end
endmodule
`default_nettype wire
